// [lcam_pkg.sv]
// lcam_pkg: constants shared by the logic cell arithmetic design.
// Assumes a single 250 MHz clock and an AXI4-Lite register slave.
`default_nettype none
package lcam_pkg;
  // cluster geometry
  localparam int LCAM_CELLS = 10;
  localparam int LCAM_HALF = 5;
  // register byte offsets
  localparam logic [7:0] LCAM_OFF_MODE = 8'h00;
  localparam logic [7:0] LCAM_OFF_LUTLO = 8'h04;
  localparam logic [7:0] LCAM_OFF_LUTHI = 8'h08;
  localparam logic [7:0] LCAM_OFF_IN = 8'h0c;
  localparam logic [7:0] LCAM_OFF_CTRL = 8'h10;
  localparam logic [7:0] LCAM_OFF_FLOPS = 8'h14;
  localparam logic [7:0] LCAM_OFF_CHAIN = 8'h18;
  localparam logic [7:0] LCAM_OFF_RESULT = 8'h1c;
  // mode register fields
  localparam int LCAM_MODE_LSB = 0;
  localparam int LCAM_FSEL_BIT = 2;
  localparam int LCAM_BYP_LSB = 4;
  localparam int LCAM_SEN_LSB = 8;
  localparam int LCAM_LEN_LSB = 12;
  localparam int LCAM_CKSRC_LSB = 16;
  localparam int LCAM_CARRYONLY_BIT = 20;
  // input register fields: a b c d e0 e1 f0 f1 (bits 0..7)
  localparam int LCAM_IN_F0 = 6;
  localparam int LCAM_IN_F1 = 7;
  // control register fields
  localparam int LCAM_CE_BIT = 0;
  localparam int LCAM_CNT_BIT = 1;
  localparam int LCAM_UP_BIT = 2;
  localparam int LCAM_SUB_BIT = 3;
  localparam int LCAM_SCLR_BIT = 4;
  localparam int LCAM_SLD_BIT = 5;
  localparam int LCAM_CKEN_LSB = 8;
  // chain register fields
  localparam int LCAM_START_LSB = 0;
  localparam int LCAM_SKIP_BIT = 4;
  localparam int LCAM_MEMCOL_BIT = 5;
  localparam int LCAM_HALFSEL_BIT = 6;
  localparam int LCAM_CIN_BIT = 7;
  // reset values
  localparam logic [31:0] LCAM_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] LCAM_RST_CTRL = 32'h0000_0701;
  // AXI response codes
  localparam logic [1:0] LCAM_RESP_OK = 2'h0;
  localparam logic [1:0] LCAM_RESP_ERR = 2'h2;
  // cell operating modes
  typedef enum logic [1:0] {
    LCAM_NORMAL = 2'b00,
    LCAM_EXT7 = 2'b01,
    LCAM_ARITH = 2'b10,
    LCAM_SHARED = 2'b11
  } lcam_mode_t;
endpackage : lcam_pkg
`default_nettype wire

// [lcam_adder.sv]
// lcam_adder: one ripple stage of two full adders with a two-bit carry select.
// Assumes combinational use inside the cell; no clock.
`default_nettype none
module lcam_adder
  import lcam_pkg::*;
(
  input wire logic [1:0] op_a,
  input wire logic [1:0] op_b,
  input wire logic carry_in,
  output logic [1:0] sum,
  output logic carry_out
);
  logic [2:0] sum_c0;
  logic [2:0] sum_c1;
  // both carry outcomes are computed ahead so the incoming carry only selects
  assign sum_c0 = {1'b0, op_a} + {1'b0, op_b};
  assign sum_c1 = {1'b0, op_a} + {1'b0, op_b} + 3'h1;
  assign sum = carry_in ? sum_c1[1:0] : sum_c0[1:0];
  assign carry_out = carry_in ? sum_c1[2] : sum_c0[2];
endmodule : lcam_adder
`default_nettype wire

// [lcam_top.sv]
// lcam_top: logic cell cluster arithmetic model behind an AXI4-Lite slave.
// Assumes one clock mclk, asynchronous active-low reset, one AXI master.
`default_nettype none
module lcam_top
  import lcam_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] clk_src,
  output logic [3:0] cell_out,
  output logic chain_carry_out
);
  // software-visible storage
  logic [31:0] mode_reg;
  logic [31:0] lutlo_reg;
  logic [31:0] luthi_reg;
  logic [31:0] in_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] chain_reg;
  logic [3:0] flop_reg;
  logic [3:0] flop_next;
  logic [3:0] out_next;
  logic carry_out_reg;
  logic [1:0] src_meta_reg;
  logic [1:0] src_sync_reg;
  logic [1:0] src_prev_reg;
  // axi handshake state
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] rdata_next;
  logic rd_ok;
  logic wr_ok;

  // byte-lane merge, used for every writable register
  function automatic logic [31:0] lcam_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : lcam_merge

  // 4-input lookup selected by four inputs from a 16-bit mask
  function automatic logic lcam_lut4(input logic [15:0] mask, input logic [3:0] sel);
    return mask[sel];
  endfunction : lcam_lut4

  // decoded configuration
  lcam_mode_t mode;
  logic use_f1;
  logic [3:0] bypass;
  logic [3:0] sync_en;
  logic [3:0] load_en;
  logic [2:0] clk_src_sel;
  logic carry_only;
  logic [7:0] din;
  assign mode = lcam_mode_t'(mode_reg[LCAM_MODE_LSB +: 2]);
  assign use_f1 = mode_reg[LCAM_FSEL_BIT];
  assign bypass = mode_reg[LCAM_BYP_LSB +: 4];
  assign sync_en = mode_reg[LCAM_SEN_LSB +: 4];
  assign load_en = mode_reg[LCAM_LEN_LSB +: 4];
  assign clk_src_sel = mode_reg[LCAM_CKSRC_LSB +: 3];
  assign carry_only = mode_reg[LCAM_CARRYONLY_BIT];
  assign din = in_reg[7:0];

  // cluster controls taken from the control register
  logic ce_in;
  logic cnt_en;
  logic cnt_up;
  logic sub_sel;
  logic sclr;
  logic sload;
  logic [2:0] cken;
  assign ce_in = ctrl_reg[LCAM_CE_BIT];
  assign cnt_en = ctrl_reg[LCAM_CNT_BIT];
  assign cnt_up = ctrl_reg[LCAM_UP_BIT];
  assign sub_sel = ctrl_reg[LCAM_SUB_BIT];
  assign sclr = ctrl_reg[LCAM_SCLR_BIT];
  assign sload = ctrl_reg[LCAM_SLD_BIT];
  assign cken = ctrl_reg[LCAM_CKEN_LSB +: 3];

  // three cluster clocks from two synchronised sources, inversion as a third source
  logic [2:0] src_edge;
  logic [2:0] clk_tick;
  assign src_edge[0] = src_sync_reg[0] & ~src_prev_reg[0];
  assign src_edge[1] = src_sync_reg[1] & ~src_prev_reg[1];
  assign src_edge[2] = ~src_sync_reg[0] & src_prev_reg[0];
  assign clk_tick = src_edge & cken & {3{ce_in}};
  // flops 0/1 on cluster clock 0 or 1, flops 2/3 on clock per select bit
  logic [3:0] flop_tick;
  assign flop_tick = {{2{clk_tick[clk_src_sel[2] ? 2 : 1]}}, {2{clk_tick[clk_src_sel[0] ? 1 : 0]}}};

  // extended mode: two five-input halves chosen by f0 or f1
  logic [5:0] six_in;
  logic half_lo;
  logic half_hi;
  logic ext_res;
  logic f_sel;
  logic f_free;
  assign six_in = din[5:0];
  assign half_lo = lutlo_reg[{1'b0, six_in[3:0]}] ^ (six_in[4] & luthi_reg[{1'b0, six_in[3:0]}]);
  assign half_hi = lutlo_reg[{1'b1, six_in[3:0]}] ^ (six_in[5] & luthi_reg[{1'b1, six_in[3:0]}]);
  assign f_sel = use_f1 ? din[LCAM_IN_F1] : din[LCAM_IN_F0];
  assign f_free = use_f1 ? din[LCAM_IN_F0] : din[LCAM_IN_F1];
  assign ext_res = f_sel ? half_hi : half_lo;

  // arithmetic mode: pre-adder lookups, two operands per adder
  logic [1:0] op_a;
  logic [1:0] op_b;
  logic [1:0] adder_sum;
  logic adder_cout;
  logic chain_cin;
  logic [3:0] lut_out;
  assign lut_out[0] = lcam_lut4(lutlo_reg[15:0], din[3:0]);
  assign lut_out[1] = lcam_lut4(lutlo_reg[31:16], din[3:0]);
  assign lut_out[2] = lcam_lut4(luthi_reg[15:0], din[7:4]);
  assign lut_out[3] = lcam_lut4(luthi_reg[31:16], din[7:4]);

  // shared mode: lookups give three-input sum and carry
  logic [1:0] sh_sum;
  logic [1:0] sh_car;
  assign sh_sum[0] = din[0] ^ din[1] ^ din[2];
  assign sh_car[0] = (din[0] & din[1]) | (din[2] & (din[0] ^ din[1]));
  assign sh_sum[1] = din[4] ^ din[5] ^ din[6];
  assign sh_car[1] = (din[4] & din[5]) | (din[6] & (din[4] ^ din[5]));

  // counters add or subtract one; outside shared mode the flops themselves are the accumulator
  logic [1:0] cnt_step;
  logic [1:0] arith_b;
  assign cnt_step = (cnt_up ^ sub_sel) ? 2'h1 : 2'h3;
  assign op_a = (mode == LCAM_SHARED) ? sh_sum : (cnt_en ? flop_reg[1:0] : {lut_out[2], lut_out[0]});
  assign arith_b = (mode == LCAM_SHARED) ? {sh_car[0], 1'b0} : {lut_out[3], lut_out[1]};
  assign op_b = cnt_en ? cnt_step : (sub_sel ? ~arith_b : arith_b);

  // chain start: carry chains at cell 1 or 5, shared chains at cell 1 or 6
  logic [3:0] start_pos;
  logic start_legal;
  logic is_start;
  logic skip_half;
  assign start_pos = chain_reg[LCAM_START_LSB +: 4];
  assign start_legal = (mode == LCAM_SHARED) ? (start_pos == 4'h1 || start_pos == 4'h6)
                                             : (start_pos == 4'h1 || start_pos == 4'h5);
  assign is_start = start_legal;
  // ordinary columns may skip only upper half, memory-capable only lower half
  assign skip_half = chain_reg[LCAM_SKIP_BIT] &
                     (chain_reg[LCAM_MEMCOL_BIT] ? ~chain_reg[LCAM_HALFSEL_BIT]
                                                 : chain_reg[LCAM_HALFSEL_BIT]);
  // a started chain takes the sub carry; a linked chain takes the previous cluster's same half
  // counters fold subtract into the step itself, so no extra start carry then
  assign chain_cin = is_start ? (sub_sel & ~cnt_en) : chain_reg[LCAM_CIN_BIT];

  lcam_adder u_adder (
    .op_a(op_a),
    .op_b(op_b),
    .carry_in(chain_cin),
    .sum(adder_sum),
    .carry_out(adder_cout)
  );

  // per-flop data selection by mode
  logic [3:0] comb_val;
  always_comb begin
    comb_val = lut_out;
    case (mode)
      LCAM_EXT7: begin
        if (use_f1) begin
          comb_val = {ext_res, ext_res, f_free, f_free};
        end else begin
          comb_val = {f_free, f_free, ext_res, ext_res};
        end
      end
      LCAM_ARITH, LCAM_SHARED: begin
        if (carry_only) begin
          comb_val = {lut_out[3], lut_out[2], lut_out[1], lut_out[0]};
        end else begin
          comb_val = {adder_sum, adder_sum};
        end
      end
      default: comb_val = lut_out;
    endcase
  end

  // flop next values: clear beats load beats data, each gated per flop
  always_comb begin
    flop_next = flop_reg;
    for (int i = 0; i < 4; i++) begin
      if (flop_tick[i]) begin
        if (sclr && sync_en[i]) begin
          flop_next[i] = 1'b0;
        end else if (sload && load_en[i]) begin
          flop_next[i] = din[i];
        end else if (mode == LCAM_NORMAL || mode == LCAM_EXT7 || !cnt_en || i < 2) begin
          flop_next[i] = comb_val[i];
        end
      end
    end
  end

  // outputs: bypassed flops show combinational value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      out_next[i] = bypass[i] ? comb_val[i] : flop_next[i];
    end
  end

  // core flops and source synchroniser
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flop_reg <= 4'h0;
      cell_out <= 4'h0;
      chain_carry_out <= 1'b0;
      carry_out_reg <= 1'b0;
      src_meta_reg <= 2'h0;
      src_sync_reg <= 2'h0;
      src_prev_reg <= 2'h0;
    end else begin
      src_meta_reg <= clk_src;
      src_sync_reg <= src_meta_reg;
      src_prev_reg <= src_sync_reg;
      flop_reg <= flop_next;
      cell_out <= out_next;
      // final carry is routed out; a skipped half passes carry-in through
      carry_out_reg <= skip_half ? chain_cin : adder_cout;
      chain_carry_out <= skip_half ? chain_cin : adder_cout;
    end
  end

  // axi write path: address and data taken in either order
  logic wr_fire;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ok = (awaddr_reg <= LCAM_OFF_CHAIN) && (awaddr_reg != LCAM_OFF_FLOPS) && (awaddr_reg[1:0] == 2'h0);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= LCAM_RST_ZERO;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= LCAM_RESP_OK;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? LCAM_RESP_OK : LCAM_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= LCAM_RST_ZERO;
      lutlo_reg <= LCAM_RST_ZERO;
      luthi_reg <= LCAM_RST_ZERO;
      in_reg <= LCAM_RST_ZERO;
      ctrl_reg <= LCAM_RST_CTRL;
      chain_reg <= LCAM_RST_ZERO;
    end else if (wr_fire) begin
      if (awaddr_reg == LCAM_OFF_MODE) begin
        mode_reg <= lcam_merge(mode_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == LCAM_OFF_LUTLO) begin
        lutlo_reg <= lcam_merge(lutlo_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == LCAM_OFF_LUTHI) begin
        luthi_reg <= lcam_merge(luthi_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == LCAM_OFF_IN) begin
        in_reg <= lcam_merge(in_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == LCAM_OFF_CTRL) begin
        ctrl_reg <= lcam_merge(ctrl_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == LCAM_OFF_CHAIN) begin
        chain_reg <= lcam_merge(chain_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  // read decode
  assign rd_ok = (s_axi_araddr <= LCAM_OFF_RESULT) && (s_axi_araddr[1:0] == 2'h0);
  always_comb begin
    rdata_next = LCAM_RST_ZERO;
    if (s_axi_araddr == LCAM_OFF_MODE) begin
      rdata_next = mode_reg;
    end else if (s_axi_araddr == LCAM_OFF_LUTLO) begin
      rdata_next = lutlo_reg;
    end else if (s_axi_araddr == LCAM_OFF_LUTHI) begin
      rdata_next = luthi_reg;
    end else if (s_axi_araddr == LCAM_OFF_IN) begin
      rdata_next = in_reg;
    end else if (s_axi_araddr == LCAM_OFF_CTRL) begin
      rdata_next = ctrl_reg;
    end else if (s_axi_araddr == LCAM_OFF_FLOPS) begin
      rdata_next = {28'h0, flop_reg};
    end else if (s_axi_araddr == LCAM_OFF_CHAIN) begin
      rdata_next = chain_reg;
    end else if (s_axi_araddr == LCAM_OFF_RESULT) begin
      rdata_next = {24'h0, start_legal, skip_half, adder_cout, carry_out_reg, adder_sum, ext_res, chain_cin};
    end
  end

  // axi read path: one outstanding read, answer one cycle after address taken
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= LCAM_RST_ZERO;
      s_axi_rresp <= LCAM_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= rd_ok ? LCAM_RESP_OK : LCAM_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : lcam_top
`default_nettype wire

// [lcam_sva.sv]
// lcam_sva: bus answer and flop timing checks on the lcam_top ports.
// Assumes it is bound into every lcam_top instance.
`default_nettype none
module lcam_sva
  import lcam_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] clk_src,
  input wire logic [3:0] cell_out,
  input wire logic chain_carry_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [3:0] quiet_reg;
  logic [1:0] src_reg;
  // cycles since a source edge or a write; saturates so it never wraps
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      quiet_reg <= 4'h0;
      src_reg <= 2'h0;
    end else begin
      src_reg <= clk_src;
      quiet_reg <= (clk_src != src_reg || s_axi_bvalid) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
    end
  end
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered in two cycles");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == LCAM_RESP_ERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_no_new_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_no_new_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_first_edge_quiet: assert property (!$past(arst_n) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("answer right after reset");
  a_flops_still: assert property (quiet_reg >= 4'h8 |-> $stable(cell_out) && $stable(chain_carry_out))
    else $error("cell output moved without a clock edge");
endmodule : lcam_sva
bind lcam_top lcam_sva u_sva (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clk_src,
  .cell_out, .chain_carry_out);
`default_nettype wire

// [lcam_nbr.sv]
// lcam_nbr: neighbouring routing that supplies the cluster clock sources.
// Assumes one request pulse on go per source pulse wanted.
`default_nettype none
module lcam_nbr (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic go,
  output logic busy,
  output logic [1:0] clk_src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] step_reg;
  // seven-step run per request, idle otherwise so sources stand still
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) step_reg <= 3'h0;
    else if (go || step_reg != 3'h0) step_reg <= step_reg + 3'h1;
  end
  // source 0 high three cycles: its fall is the inverted source
  assign clk_src = {1'b0, step_reg != 3'h0 && !step_reg[2]};
  assign busy = step_reg != 3'h0;
endmodule : lcam_nbr
`default_nettype wire

// [lcam_tb_top.sv]
// lcam_tb_top: self-checking bench for lcam_top over AXI4-Lite.
// Assumes lcam_nbr drives the cluster clock sources.
`default_nettype none
module lcam_tb_top
  import lcam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r; logic [7:0] a;} lcam_note_t;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, go = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy, carry;
  logic [1:0] bresp, rresp, clk_src;
  logic [31:0] rdata;
  logic [3:0] cell_out;
  logic [3:0] ts [8] = '{4'h1, 4'h5, 4'h3, 4'h6, 4'ha, 4'h1, 4'h6, 4'h5};
  logic [7:0] tl = 8'h63;
  lcam_note_t rq[$];
  lcam_note_t nt;
  logic [1:0] wq[$];
  int errors = 0;
  int cmp_count = 0;
  lcam_top u_dut (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clk_src(clk_src),
    .cell_out(cell_out), .chain_carry_out(carry));
  lcam_nbr u_nbr (.mclk(mclk), .arst_n(arst_n), .go(go), .busy(busy), .clk_src(clk_src));
  // 250 MHz
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // answers are matched against the oldest note on their queue
  always @(posedge mclk) begin
    if (rvalid && rready && rq.size() > 0) begin
      nt = rq.pop_front();
      chk($sformatf("rdata at %h", nt.a), nt.d, rdata & nt.m);
      chk("rresp", {30'h0, nt.r}, {30'h0, rresp});
    end
    if (bvalid && bready && wq.size() > 0) chk("bresp", {30'h0, wq.pop_front()}, {30'h0, bresp});
  end
  // the leading edge keeps a ready from being lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge mclk);
    n = 0;
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) chk("bvalid", 32'h1, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    int n;
    @(posedge mclk);
    n = 0;
    rq.push_back('{d, m, r, a});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) chk("rvalid", 32'h1, 32'h0);
  endtask : rd
  // source pulses, then room for the two-flop synchroniser
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge mclk);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      while (busy) @(posedge mclk);
      repeat (6) @(posedge mclk);
    end
  endtask : pulse
  // flops 2 and 3 run on cluster clock 1, whose source never moves, so they stay clear
  task automatic flops(input logic [1:0] e);
    rd(LCAM_OFF_FLOPS, {28'h0, 2'b00, e}, 32'hf, LCAM_RESP_OK);
    chk("cell_out", {28'h0, 2'b00, e}, {28'h0, cell_out});
  endtask : flops
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    logic [31:0] v;
    v = $urandom(1);
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    rd(LCAM_OFF_MODE, LCAM_RST_ZERO, ALL, LCAM_RESP_OK);
    rd(LCAM_OFF_CTRL, LCAM_RST_CTRL, ALL, LCAM_RESP_OK);
    rd(LCAM_OFF_CHAIN, LCAM_RST_ZERO, ALL, LCAM_RESP_OK);
    rd(8'h20, 32'h0, ALL, LCAM_RESP_ERR);
    rd(8'h06, 32'h0, ALL, LCAM_RESP_ERR);
    wr(LCAM_OFF_FLOPS, 32'hf, LCAM_RESP_ERR);
    wr(LCAM_OFF_RESULT, 32'hff, LCAM_RESP_ERR);
    rd(LCAM_OFF_FLOPS, 32'h0, ALL, LCAM_RESP_OK);
    $display("test registers done");
    // one half of the mask set, the other clear: the chosen f input picks the result
    for (int i = 0; i < 4; i++) begin
      wr(LCAM_OFF_MODE, {29'h0, i[0], 2'b01}, LCAM_RESP_OK);
      wr(LCAM_OFF_LUTLO, i[1] ? 32'hffff_0000 : 32'h0000_ffff, LCAM_RESP_OK);
      wr(LCAM_OFF_LUTHI, 32'h0000_0000, LCAM_RESP_OK);
      v = $urandom & 32'hff;
      wr(LCAM_OFF_IN, v, LCAM_RESP_OK);
      rd(LCAM_OFF_RESULT, {30'h0, (i[0] ? v[LCAM_IN_F1] : v[LCAM_IN_F0]) ^ ~i[1], 1'b0}, 32'h2, LCAM_RESP_OK);
    end
    $display("test extended lookup done");
    // carry chain starts in arithmetic mode, then shared chain starts
    for (int i = 0; i < 8; i++) begin
      wr(LCAM_OFF_MODE, (i < 5) ? 32'h2 : 32'h3, LCAM_RESP_OK);
      wr(LCAM_OFF_CHAIN, {28'h0, ts[i]}, LCAM_RESP_OK);
      rd(LCAM_OFF_RESULT, {24'h0, tl[i], 7'h0}, 32'h80, LCAM_RESP_OK);
    end
    $display("test chain start done");
    // half skip: ordinary column frees upper half, memory-capable the lower
    // cell five is no shared start, so the previous cluster's carry is taken and passed on
    for (int i = 0; i < 4; i++) begin
      wr(LCAM_OFF_CHAIN, {24'h0, 1'b1, i[1], i[0], 5'h15}, LCAM_RESP_OK);
      rd(LCAM_OFF_RESULT, {25'h0, i[0] ^ i[1], 6'h01}, 32'h41, LCAM_RESP_OK);
      if (i[0] ^ i[1]) chk("chain_carry_out", 32'h1, {31'h0, carry});
    end
    $display("test half skip done");
    wr(LCAM_OFF_MODE, 32'h0000_0002, LCAM_RESP_OK);
    wr(LCAM_OFF_CTRL, 32'h0000_0707, LCAM_RESP_OK);
    pulse(3);
    flops(2'h3);
    wr(LCAM_OFF_CTRL, 32'h0000_0713, LCAM_RESP_OK);
    pulse(1);
    flops(2'h2);
    wr(LCAM_OFF_MODE, 32'h0000_0302, LCAM_RESP_OK);
    pulse(1);
    flops(2'h0);
    wr(LCAM_OFF_CTRL, 32'h0000_0007, LCAM_RESP_OK);
    pulse(1);
    flops(2'h0);
    wr(LCAM_OFF_CTRL, 32'h0000_0703, LCAM_RESP_OK);
    pulse(1);
    flops(2'h3);
    wr(LCAM_OFF_CTRL, 32'h0000_0706, LCAM_RESP_OK);
    pulse(1);
    flops(2'h3);
    wr(LCAM_OFF_CTRL, 32'h0000_070f, LCAM_RESP_OK);
    pulse(1);
    flops(2'h2);
    $display("test counter done");
    finish_test();
  end
endmodule : lcam_tb_top
`default_nettype wire
